// *** rtl/open_pole_pkg.sv ***
// Constants, register map and types for the open pole detector
package open_pole_pkg;
   localparam int MAG_W = 16;
   // Magnitudes and thresholds are unsigned per-unit, 1.0 = 16'h1000
   localparam logic [15:0] IMIN_RST = 16'h019A;
   localparam logic [15:0] UMIN_RST = 16'h0800;
   localparam int CLK_PERIOD_PS = 5000;
   localparam int TRIP_MEM_NS = 20000;
   localparam logic [11:0] TRIP_MEM_CYC = 12'(TRIP_MEM_NS * 1000 / CLK_PERIOD_PS);
   // Register byte offsets
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] CONN_OFS = 12'h004;
   localparam logic [11:0] IMIN_OFS = 12'h008;
   localparam logic [11:0] UMIN_OFS = 12'h00C;
   localparam logic [11:0] STAT_OFS = 12'h010;
   // Control fields
   localparam int CTRL_OPER = 0;
   localparam int CTRL_RES = 1;
   localparam int CTRL_VOLT = 2;
   localparam int CTRL_CONT = 3;
   localparam int CTRL_LINE_OR = 4;
   localparam logic [4:0] CTRL_RST = 5'h00;
   // Connection fields
   localparam int CONN_B1 = 0;
   localparam int CONN_B1_3PH = 1;
   localparam int CONN_B2 = 2;
   localparam int CONN_B2_3PH = 3;
   localparam int CONN_U = 4;
   localparam int CONN_U_3PE = 5;
   localparam int CONN_TRIP = 6;
   localparam int CONN_EXT = 9;
   localparam int CONN_PICKUP = 10;
   localparam int CONN_C1 = 11;
   localparam int CONN_C2 = 14;
   localparam logic [16:0] CONN_RST = 17'h0_01C3;
   // Health codes
   localparam logic [1:0] HEALTH_OK = 2'h0;
   localparam logic [1:0] HEALTH_WARN = 2'h1;
   localparam logic [1:0] HEALTH_ALARM = 2'h2;
   typedef logic [2:0][MAG_W-1:0] mag3_t;
endpackage

// *** rtl/open_pole_detector.sv ***
// Open pole detector: criteria, trip record, line combine and APB registers
// Functional notes
// - Three criteria, residual, voltage and contact, each enabled on its own.
// - With one breaker connected, line outputs copy that breaker.
// - With two breakers, line is OR or AND as selected.
// - Per-phase outputs for each breaker and the line, plus aggregates.
// - Residual: exactly one phase current low, the other two high.
// - Residual: residual current magnitude must exceed current threshold.
// - Current thresholds are per unit of rated CT primary current.
// - Residual needs trip indication; per-phase trips preferred, external trip fallback.
// - Residual and voltage open pole only after a recent trip; recent trips are remembered.
// - With per-phase trips, tripped phase must match low-current phase.
// - Connected pickups act like trips for faults cleared elsewhere.
// - Voltage criterion only with three phase-to-earth voltages connected.
// - Voltage: the low-current phase alone has low voltage, others high.
// - Voltage threshold per unit of rated VT voltage over root three.
// - Voltage criterion uses the same trip and pickup handling.
// - Contact: one phase current low and only its contact active.
// - Contact criterion needs no trip or pickup.
// - Two breakers need both current channels; contact criterion works per breaker whose full contact set is connected.
// - Alarm health and no detection on bad current setup or no criterion.
// - Warning health on partial voltage, trip or contact connection.
// - Evaluation with minimal latency, one register stage.
// - Current threshold resets to one tenth of rated.
// - Voltage threshold resets to one half of rated.
`timescale 1ns/1ps
module open_pole_detector
   import open_pole_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Measurements
   input wire mag3_t brk1_phase_currents,
   input wire logic [MAG_W-1:0] brk1_residual_current,
   input wire mag3_t brk2_phase_currents,
   input wire logic [MAG_W-1:0] brk2_residual_current,
   input wire mag3_t phase_voltages,
   // Trip and pickup indications
   input wire logic trip_phase_a,
   input wire logic trip_phase_b,
   input wire logic trip_phase_c,
   input wire logic prot_trip_in_a,
   input wire logic prot_trip_in_b,
   input wire logic prot_trip_in_c,
   input wire logic external_single_pole_trip,
   input wire logic pickup_phase_a,
   input wire logic pickup_phase_b,
   input wire logic pickup_phase_c,
   // Normally closed auxiliary contacts
   input wire logic brk1_contact_open_a,
   input wire logic brk1_contact_open_b,
   input wire logic brk1_contact_open_c,
   input wire logic brk2_contact_open_a,
   input wire logic brk2_contact_open_b,
   input wire logic brk2_contact_open_c,
   // Open pole outputs
   output logic brk1_pole_open_a,
   output logic brk1_pole_open_b,
   output logic brk1_pole_open_c,
   output logic brk2_pole_open_a,
   output logic brk2_pole_open_b,
   output logic brk2_pole_open_c,
   output logic line_pole_open_a,
   output logic line_pole_open_b,
   output logic line_pole_open_c,
   output logic brk1_pole_open,
   output logic brk2_pole_open,
   output logic line_pole_open,
   output logic [1:0] health
);

   typedef struct packed {
      logic [4:0] ctrl;
      logic [16:0] conn;
      logic [15:0] imin;
      logic [15:0] umin;
      logic [3:0][11:0] rec_cnt;
      logic [2:0] p1;
      logic [2:0] p2;
      logic [2:0] line;
      logic [1:0] health;
      logic [31:0] prdata;
   } state_s;

   state_s s;
   state_s next_s;

   // One-hot of the single phase below thr while the other two are above it
   function automatic logic [2:0] single_low(input mag3_t m, input logic [15:0] thr);
      logic [2:0] lo;
      logic [2:0] hi;
      lo = '0;
      hi = '0;
      for (int i = 0; i < 3; i++)
      begin
         lo[i] = m[i] < thr;
         hi[i] = m[i] > thr;
      end
      return {lo[2] & hi[1] & hi[0], lo[1] & hi[2] & hi[0], lo[0] & hi[2] & hi[1]};
   endfunction

   function automatic logic [2:0] one_only(input logic [2:0] v);
      return (v == 3'b001 || v == 3'b010 || v == 3'b100) ? v : 3'b000;
   endfunction

   logic acc;
   logic [11:0] waddr;
   logic mapped;
   logic [2:0] trip_ev;
   logic [2:0] rec_ph;
   logic rec_ext;
   logic phase_trips;
   logic trip_avail;
   logic [2:0] trip_ok;
   logic [2:0] cur1;
   logic [2:0] cur2;
   logic [2:0] ulow;
   logic b1_on;
   logic b2_on;
   logic c1_full;
   logic c2_full;
   logic res_ok;
   logic volt_ok;
   logic cont_ok;
   logic alarm;
   logic warn;
   logic [2:0] cand1;
   logic [2:0] cand2;

   assign pready = 1'b1;
   assign acc = psel & penable;
   assign waddr = paddr;
   assign mapped = waddr == CTRL_OFS || waddr == CONN_OFS || waddr == IMIN_OFS ||
                   waddr == UMIN_OFS || waddr == STAT_OFS;
   assign pslverr = acc & ~mapped;

   always_comb
   begin
      next_s = s;
      trip_ev = {trip_phase_c | prot_trip_in_c, trip_phase_b | prot_trip_in_b,
                 trip_phase_a | prot_trip_in_a};
      // Pickups count as trips so faults cleared by other relays are seen
      if (s.conn[CONN_PICKUP])
         trip_ev = trip_ev | {pickup_phase_c, pickup_phase_b, pickup_phase_a};
      // Short trip memory bridges the gap between trip and current loss
      for (int i = 0; i < 4; i++)
      begin
         if ((i < 3) ? trip_ev[i] : (external_single_pole_trip & s.conn[CONN_EXT]))
            next_s.rec_cnt[i] = TRIP_MEM_CYC;
         else if (s.rec_cnt[i] != '0)
            next_s.rec_cnt[i] = s.rec_cnt[i] - 12'h001;
      end
      for (int i = 0; i < 3; i++)
         rec_ph[i] = s.rec_cnt[i] != '0;
      rec_ext = s.rec_cnt[3] != '0;
      phase_trips = &s.conn[CONN_TRIP +: 3];
      trip_avail = phase_trips | s.conn[CONN_EXT] | s.conn[CONN_PICKUP];
      // Matched phase record is preferred; external trip only as fallback
      trip_ok = phase_trips ? rec_ph : (rec_ph | {3{rec_ext}});
      b1_on = s.conn[CONN_B1];
      b2_on = s.conn[CONN_B2];
      c1_full = &s.conn[CONN_C1 +: 3];
      c2_full = &s.conn[CONN_C2 +: 3];
      res_ok = s.ctrl[CTRL_RES] & trip_avail;
      volt_ok = s.ctrl[CTRL_VOLT] & trip_avail & s.conn[CONN_U] & s.conn[CONN_U_3PE];
      cont_ok = s.ctrl[CTRL_CONT] & ((b1_on & c1_full) | (b2_on & c2_full));
      alarm = ~(b1_on | b2_on) | (b1_on & ~s.conn[CONN_B1_3PH]) |
              (b2_on & ~s.conn[CONN_B2_3PH]) | ~(res_ok | volt_ok | cont_ok);
      warn = (s.conn[CONN_U] & ~s.conn[CONN_U_3PE]) |
             (|s.conn[CONN_TRIP +: 3] & ~phase_trips) |
             (b1_on & |s.conn[CONN_C1 +: 3] & ~c1_full) |
             (b2_on & |s.conn[CONN_C2 +: 3] & ~c2_full);
      // Thresholds are per unit; voltages arrive scaled to rated/root three
      cur1 = single_low(brk1_phase_currents, s.imin);
      cur2 = single_low(brk2_phase_currents, s.imin);
      ulow = single_low(phase_voltages, s.umin);
      cand1 = '0;
      cand2 = '0;
      if (res_ok)
      begin
         if (brk1_residual_current > s.imin)
            cand1 = cand1 | (cur1 & trip_ok);
         if (brk2_residual_current > s.imin)
            cand2 = cand2 | (cur2 & trip_ok);
      end
      if (volt_ok)
      begin
         cand1 = cand1 | (cur1 & ulow & trip_ok);
         cand2 = cand2 | (cur2 & ulow & trip_ok);
      end
      // Once declared, a pole stays open while its current stays alone low and residual or voltage criterion is usable
      cand1 = cand1 | (s.p1 & cur1 & {3{res_ok | volt_ok}});
      cand2 = cand2 | (s.p2 & cur2 & {3{res_ok | volt_ok}});
      if (cont_ok)
      begin
         if (c1_full)
            cand1 = cand1 | (cur1 & one_only({brk1_contact_open_c, brk1_contact_open_b,
                                              brk1_contact_open_a}));
         if (c2_full)
            cand2 = cand2 | (cur2 & one_only({brk2_contact_open_c, brk2_contact_open_b,
                                              brk2_contact_open_a}));
      end
      if (alarm | ~s.ctrl[CTRL_OPER] | ~b1_on)
         cand1 = '0;
      if (alarm | ~s.ctrl[CTRL_OPER] | ~b2_on)
         cand2 = '0;
      next_s.p1 = cand1;
      next_s.p2 = cand2;
      if (b1_on & b2_on)
         next_s.line = s.ctrl[CTRL_LINE_OR] ? (cand1 | cand2) : (cand1 & cand2);
      else
         next_s.line = cand1 | cand2;
      next_s.health = alarm ? HEALTH_ALARM : (warn ? HEALTH_WARN : HEALTH_OK);
      // Read data is captured in the setup cycle so it is a flop in the access cycle
      if (psel & ~penable)
      begin
         case (waddr)
            CTRL_OFS: next_s.prdata = {27'h000_0000, s.ctrl};
            CONN_OFS: next_s.prdata = {15'h0000, s.conn};
            IMIN_OFS: next_s.prdata = {16'h0000, s.imin};
            UMIN_OFS: next_s.prdata = {16'h0000, s.umin};
            STAT_OFS: next_s.prdata = {21'h00_0000, s.health, s.line, s.p2, s.p1};
            default: next_s.prdata = '0;
         endcase
      end
      if (acc & pwrite)
      begin
         case (waddr)
            CTRL_OFS: next_s.ctrl = pwdata[4:0];
            CONN_OFS: next_s.conn = pwdata[16:0];
            IMIN_OFS: next_s.imin = pwdata[15:0];
            UMIN_OFS: next_s.umin = pwdata[15:0];
            default: next_s.ctrl = s.ctrl;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s <= '0;
         s.ctrl <= CTRL_RST;
         s.conn <= CONN_RST;
         s.imin <= IMIN_RST;
         s.umin <= UMIN_RST;
         s.health <= HEALTH_OK;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign prdata = s.prdata;
   assign {brk1_pole_open_c, brk1_pole_open_b, brk1_pole_open_a} = s.p1;
   assign {brk2_pole_open_c, brk2_pole_open_b, brk2_pole_open_a} = s.p2;
   assign {line_pole_open_c, line_pole_open_b, line_pole_open_a} = s.line;
   assign brk1_pole_open = |s.p1;
   assign brk2_pole_open = |s.p2;
   assign line_pole_open = |s.line;
   assign health = s.health;

   sequence s_phase_a_trip;
      trip_phase_a && s.conn[CONN_TRIP +: 3] == 3'b111;
   endsequence

   // A trip that is still present in the load cycle reloads the record instead
   property p_trip_record;
      @(posedge pclk) disable iff (!presetn)
      s_phase_a_trip |=> s.rec_cnt[0] == TRIP_MEM_CYC ##1
         (s.rec_cnt[0] == TRIP_MEM_CYC - 12'h001 || $past(trip_ev[0]));
   endproperty
   a_trip_record: assert property (p_trip_record) else $error("trip record not loaded");

   property p_single_breaker_line;
      @(posedge pclk) disable iff (!presetn)
      $past(s.conn[CONN_B1] && !s.conn[CONN_B2]) |-> s.line == s.p1;
   endproperty
   a_single_breaker_line: assert property (p_single_breaker_line) else $error("line not breaker 1");

   property p_line_combine;
      @(posedge pclk) disable iff (!presetn)
      $past(s.conn[CONN_B1] && s.conn[CONN_B2]) |->
         s.line == ($past(s.ctrl[CTRL_LINE_OR]) ? (s.p1 | s.p2) : (s.p1 & s.p2));
   endproperty
   a_line_combine: assert property (p_line_combine) else $error("line combine wrong");

   property p_one_phase;
      @(posedge pclk) disable iff (!presetn)
      $onehot0(s.p1) && $onehot0(s.p2);
   endproperty
   a_one_phase: assert property (p_one_phase) else $error("more than one pole open");

   property p_alarm_quiet;
      @(posedge pclk) disable iff (!presetn)
      alarm |=> s.p1 == 3'b000 && s.p2 == 3'b000 && s.health == HEALTH_ALARM;
   endproperty
   a_alarm_quiet: assert property (p_alarm_quiet) else $error("detection under alarm");

   property p_needs_low_current;
      @(posedge pclk) disable iff (!presetn)
      s.p1[0] |-> $past(brk1_phase_currents[0] < s.imin);
   endproperty
   a_needs_low_current: assert property (p_needs_low_current) else $error("pole open, current high");

   // Contact criterion must fire on any phase with no trip record at all
   property p_contact_no_trip;
      @(posedge pclk) disable iff (!presetn)
      (!alarm && s.ctrl[CTRL_OPER] && s.ctrl[CTRL_CONT] && b1_on && c1_full &&
       (cur1 & one_only({brk1_contact_open_c, brk1_contact_open_b,
                         brk1_contact_open_a})) != 3'b000) |=> s.p1 == $past(cur1);
   endproperty
   a_contact_no_trip: assert property (p_contact_no_trip) else $error("contact pole missed");

   property p_residual_needs_trip;
      @(posedge pclk) disable iff (!presetn)
      ($rose(s.p1[2]) && !$past(s.ctrl[CTRL_CONT]) && $past(phase_trips)) |->
         $past(s.rec_cnt[2] != 12'h000);
   endproperty
   a_residual_needs_trip: assert property (p_residual_needs_trip) else $error("pole without trip");

   property p_write_ctrl;
      @(posedge pclk) disable iff (!presetn)
      (acc && pwrite && waddr == CTRL_OFS) |=> s.ctrl == $past(pwdata[4:0]);
   endproperty
   a_write_ctrl: assert property (p_write_ctrl) else $error("control write lost");
endmodule

// *** verification/breaker_model.sv ***
// Far side model: trip logic, breaker 1 contacts and breaker 1 current front end
`timescale 1ns/1ps
module breaker_model
   import open_pole_pkg::*;
(
   // Clock
   input wire logic pclk,
   // Bench commands
   input wire logic [2:0] trip_cmd,
   input wire logic [2:0] open_cmd,
   input wire logic [MAG_W-1:0] load_mag,
   input wire logic [MAG_W-1:0] res_mag,
   // Toward the detector
   output logic [2:0] trip,
   output logic [2:0] contact_open,
   output mag3_t currents,
   output logic [MAG_W-1:0] residual
);
   // An open pole still shows a small leakage, never a clean zero
   always_ff @(posedge pclk)
   begin
      trip <= trip_cmd;
      contact_open <= open_cmd;
      for (int i = 0; i < 3; i++)
         currents[i] <= open_cmd[i] ? 16'h0010 : load_mag;
      residual <= (open_cmd != 3'b000) ? res_mag : 16'h0000;
   end
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the open pole detector
`timescale 1ns/1ps
module tb
   import open_pole_pkg::*;
;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [2:0] trip_cmd = 3'b000, open_cmd = 3'b000, pick = 3'b000, c2 = 3'b000;
   logic [MAG_W-1:0] res_mag = 16'h0800;
   mag3_t cur2 = {3{16'h1000}}, volts = {3{16'h1000}};
   wire [31:0] prdata;
   wire pready, pslverr, brk1_any, brk2_any, line_any;
   wire [2:0] trip, c1, b1, b2, ln;
   wire mag3_t cur1;
   wire [MAG_W-1:0] res1;
   wire [1:0] health;
   logic [31:0] q;
   logic e, ext = 1'b0;
   int bad_count = 0, check_count = 0, cycles = 0;

   open_pole_detector dut (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .brk1_phase_currents(cur1), .brk1_residual_current(res1),
      .brk2_phase_currents(cur2), .brk2_residual_current(16'h0000), .phase_voltages(volts),
      .trip_phase_a(trip[0]), .trip_phase_b(trip[1]), .trip_phase_c(trip[2]),
      .prot_trip_in_a(1'b0), .prot_trip_in_b(1'b0), .prot_trip_in_c(1'b0),
      .external_single_pole_trip(ext),
      .pickup_phase_a(pick[0]), .pickup_phase_b(pick[1]), .pickup_phase_c(pick[2]),
      .brk1_contact_open_a(c1[0]), .brk1_contact_open_b(c1[1]), .brk1_contact_open_c(c1[2]),
      .brk2_contact_open_a(c2[0]), .brk2_contact_open_b(c2[1]), .brk2_contact_open_c(c2[2]),
      .brk1_pole_open_a(b1[0]), .brk1_pole_open_b(b1[1]), .brk1_pole_open_c(b1[2]),
      .brk2_pole_open_a(b2[0]), .brk2_pole_open_b(b2[1]), .brk2_pole_open_c(b2[2]),
      .line_pole_open_a(ln[0]), .line_pole_open_b(ln[1]), .line_pole_open_c(ln[2]),
      .brk1_pole_open(brk1_any), .brk2_pole_open(brk2_any), .line_pole_open(line_any), .health
   );

   breaker_model far (
      .pclk, .trip_cmd, .open_cmd, .load_mag(16'h1000), .res_mag, .trip,
      .contact_open(c1), .currents(cur1), .residual(res1)
   );

   initial
      forever #2.5 pclk = ~pclk;

   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Far longer than the whole sequence, which stays under 45000 cycles
   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 60000)
      begin
         bad_count++;
         test_done();
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // Called right after a rising edge; leaves one idle cycle behind
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      tick(1);
      penable <= 1'b1;
      do
         tick(1);
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      tick(1);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
      apb(1'b0, a, 32'h0000_0000);
      check("read data", q, exp);
      check("read error", 32'(e), 32'(err));
      check("ready", 32'(pready), 32'h0000_0001);
   endtask

   task automatic poles(input logic [2:0] e1, input logic [2:0] e2, input logic [2:0] el);
      check("brk1 poles", 32'({brk1_any, b1}), 32'({|e1, e1}));
      check("brk2 poles", 32'({brk2_any, b2}), 32'({|e2, e2}));
      check("line poles", 32'({line_any, ln}), 32'({|el, el}));
   endtask

   task automatic trip_open(input logic [2:0] t, input logic [2:0] o);
      trip_cmd <= t;
      tick(1);
      trip_cmd <= 3'b000;
      open_cmd <= o;
      tick(4);
   endtask

   // Waiting out the trip memory keeps one case from enabling the next
   task automatic close_all;
      open_cmd <= 3'b000;
      tick(int'(TRIP_MEM_CYC) + 4);
   endtask

   function automatic logic [MAG_W-1:0] pick_mag(input int r);
      case (r)
         0: return IMIN_RST - 16'h0001;
         1: return IMIN_RST;
         2: return IMIN_RST + 16'h0001;
         default: return 16'h1000;
      endcase
   endfunction

   function automatic logic [2:0] cont_exp(input mag3_t m, input logic [2:0] c);
      logic [2:0] lo;
      logic [2:0] hi;
      for (int i = 0; i < 3; i++)
      begin
         lo[i] = m[i] < IMIN_RST;
         hi[i] = m[i] > IMIN_RST;
      end
      return (((lo | hi) == 3'b111) && ($countones(lo) == 1) && (c == lo)) ? lo : 3'b000;
   endfunction

   initial
   begin
      void'($urandom(13654));
      tick(6);
      presetn <= 1'b1;
      tick(2);
      check("health", 32'(health), 32'(HEALTH_ALARM));
      rd(CTRL_OFS, 32'(CTRL_RST), 1'b0);
      rd(CONN_OFS, 32'(CONN_RST), 1'b0);
      rd(IMIN_OFS, 32'(IMIN_RST), 1'b0);
      rd(UMIN_OFS, 32'(UMIN_RST), 1'b0);
      rd(STAT_OFS, 32'h0000_0400, 1'b0);
      rd(12'h014, 32'h0000_0000, 1'b1);
      apb(1'b1, CTRL_OFS, 32'h0000_0003);
      tick(2);
      check("health", 32'(health), 32'(HEALTH_OK));
      open_cmd <= 3'b001;
      tick(4);
      poles(3'b000, 3'b000, 3'b000);
      close_all();
      for (int p = 0; p < 3; p++)
      begin
         trip_open(3'b001 << p, 3'b001 << p);
         poles(3'b001 << p, 3'b000, 3'b001 << p);
         close_all();
         poles(3'b000, 3'b000, 3'b000);
      end
      trip_open(3'b010, 3'b001);
      poles(3'b000, 3'b000, 3'b000);
      close_all();
      trip_open(3'b001, 3'b011);
      poles(3'b000, 3'b000, 3'b000);
      close_all();
      res_mag <= IMIN_RST;
      trip_open(3'b100, 3'b100);
      poles(3'b000, 3'b000, 3'b000);
      close_all();
      res_mag <= 16'h0800;
      apb(1'b1, CONN_OFS, 32'(CONN_RST) | 32'h0000_0400);
      pick <= 3'b010;
      tick(1);
      pick <= 3'b000;
      open_cmd <= 3'b010;
      tick(4);
      poles(3'b010, 3'b000, 3'b010);
      close_all();
      apb(1'b1, CONN_OFS, 32'h0000_0203);
      ext <= 1'b1;
      tick(1);
      ext <= 1'b0;
      open_cmd <= 3'b100;
      tick(4);
      poles(3'b100, 3'b000, 3'b100);
      close_all();
      apb(1'b1, CTRL_OFS, 32'h0000_0005);
      apb(1'b1, CONN_OFS, 32'(CONN_RST) | 32'h0000_0030);
      volts[2] <= 16'h0100;
      trip_open(3'b100, 3'b100);
      poles(3'b100, 3'b000, 3'b100);
      close_all();
      volts <= {3{16'h1000}};
      apb(1'b1, CTRL_OFS, 32'h0000_0007);
      apb(1'b1, CONN_OFS, 32'(CONN_RST) | 32'h0000_0010);
      tick(2);
      check("health", 32'(health), 32'(HEALTH_WARN));
      apb(1'b1, CONN_OFS, 32'h0000_01C1);
      tick(2);
      check("health", 32'(health), 32'(HEALTH_ALARM));
      apb(1'b1, CTRL_OFS, 32'h0000_0009);
      apb(1'b1, CONN_OFS, 32'h0001_F9CF);
      open_cmd <= 3'b001;
      tick(4);
      poles(3'b001, 3'b000, 3'b000);
      apb(1'b1, CTRL_OFS, 32'h0000_0019);
      tick(2);
      poles(3'b001, 3'b000, 3'b001);
      open_cmd <= 3'b000;
      apb(1'b1, CTRL_OFS, 32'h0000_000B);
      apb(1'b1, CONN_OFS, 32'h0000_41CC);
      tick(2);
      check("health", 32'(health), 32'(HEALTH_WARN));
      apb(1'b1, CTRL_OFS, 32'h0000_0009);
      apb(1'b1, CONN_OFS, 32'h0001_C00C);
      for (int n = 0; n < 200; n++)
      begin
         for (int i = 0; i < 3; i++)
            cur2[i] <= pick_mag($urandom_range(5));
         c2 <= ($urandom_range(3) != 0) ? 3'b001 << $urandom_range(2) : 3'($urandom_range(7));
         tick(3);
         poles(3'b000, cont_exp(cur2, c2), cont_exp(cur2, c2));
      end
      test_done();
   end
endmodule
